// ==== core/adf_pkg.sv ====
/*
 * adf_pkg: register offsets, field positions and reset values of the
 * amplifier fault and diagnostic status bank.
 * assumes: the serial control front end presents byte addresses as printed.
 */
package adf_pkg;
    localparam int          NUM_CH            = 4;
    localparam logic [7:0]  ADDR_LOAD_CH12    = 8'h0C;
    localparam logic [7:0]  ADDR_LOAD_CH34    = 8'h0D;
    localparam logic [7:0]  ADDR_LINE_OUT     = 8'h0E;
    localparam logic [7:0]  ADDR_CH_STATE     = 8'h0F;
    localparam logic [7:0]  ADDR_CH_FAULT     = 8'h10;
    localparam logic [7:0]  ADDR_SUPPLY_CLK   = 8'h11;
    localparam logic [7:0]  ADDR_THERMAL      = 8'h12;
    localparam logic [7:0]  RST_LOAD          = 8'h00;
    localparam logic [3:0]  RST_LINE_OUT      = 4'h0;
    localparam logic [7:0]  RST_CH_STATE      = 8'h55;
    localparam logic [7:0]  RST_CH_FAULT      = 8'h00;
    localparam logic [4:0]  RST_GLOBAL        = 5'h00;
    localparam logic [3:0]  RST_SHORT_THRESH  = 4'h1;
    localparam logic [7:0]  UNMAPPED_DATA     = 8'h00;
    // channel state encodings
    localparam logic [1:0]  STATE_PLAY        = 2'h0;
    localparam logic [1:0]  STATE_HIGH_IMP    = 2'h1;
    localparam logic [1:0]  STATE_MUTE        = 2'h2;
    localparam logic [1:0]  STATE_DC_DIAG     = 2'h3;
    // nibble bit positions, high to low
    localparam int          NIB_S2G           = 3;
    localparam int          NIB_S2P           = 2;
    localparam int          NIB_OPEN          = 1;
    localparam int          NIB_SHORTED       = 0;
    // supply and clock register bits
    localparam int          GB_CLOCK          = 4;
    localparam int          GB_OUT_HIGH       = 3;
    localparam int          GB_BAT_HIGH       = 2;
    localparam int          GB_OUT_LOW        = 1;
    localparam int          GB_BAT_LOW        = 0;
    typedef struct packed {
        logic [7:0] load12;
        logic [7:0] load34;
        logic [3:0] line_out;
        logic [7:0] ch_state;
        logic [7:0] ch_fault;
        logic [4:0] supply_clk;
        logic [4:0] thermal;
        logic [7:0] rdata;
        logic       rvalid;
    } adf_state_t;
endpackage

// ==== core/adf_status_bank.sv ====
/*
 * adf_status_bank: read-only fault and diagnostic status registers.
 * assumes: diagnostic engines give one-cycle done strobes per channel with
 * their flags valid in that cycle; all inputs are synchronous to REF_CLK_I.
 */
// Contract
// [R1] ch34 load report: ch3 bits 7-4, ch4 bits 3-0, s2g,s2p,open,shorted.
// [R2] ch12 load report: ch1 in bits 7-4, ch2 in bits 3-0, same order.
// [R3] load report bits read 1 when detected, else 0; reset to 0.
// [R4] line-out report bits 3..0 for ch1..ch4; bits 7-4 read zero.
// [R5] channel state report: two bits per channel, ch1 at top.
// [R6] state codes: play 00, high impedance 01, mute 10, diagnostics 11.
// [R7] channel state report reads 0x55 after reset.
// [R8] channel faults: overcurrent ch1-4 in bits 7-4, dc ch1-4 in 3-0.
// [R9] overcurrent and dc flags read 1 when detected, reset to 0.
// [R10] supply/clock register: bits 7-5 zero, bits 4-0 clock and supply flags.
// [R11] bit 4 reads 1 on an invalid input clock, else 0.
// [R12] bit 3 output supply overvoltage, bit 2 battery overvoltage.
// [R13] bit 1 output supply undervoltage, bit 0 battery undervoltage.
// [R14] thermal shutdown register at next address, resets to 0x00.
// [R15] shorted load judged against per-channel threshold, default code 0001.
// [R16] line-out results only taken while line-out diagnostics enabled.
// [R17] host writes leave every register unchanged; reserved bits don't-care.
module adf_status_bank (
    input  wire logic        REF_CLK_I,
    input  wire logic        NRST_I,
    input  wire logic        CE_I,
    input  wire logic [7:0]  REG_ADDR_I,
    input  wire logic        REG_RD_I,
    input  wire logic        REG_WR_I,
    input  wire logic [7:0]  REG_WDATA_I,
    output logic      [7:0]  REG_RDATA_O,
    output logic             REG_RVALID_O,
    input  wire logic [3:0]  DIAG_DONE_I,
    input  wire logic [3:0]  SHORT_TO_GROUND_I,
    input  wire logic [3:0]  SHORT_TO_POWER_I,
    input  wire logic [3:0]  OPEN_LOAD_I,
    input  wire logic [15:0] LOAD_CODE_I,
    input  wire logic [15:0] SHORT_THRESHOLD_I,
    input  wire logic        LINE_OUT_DIAG_ENABLE_I,
    input  wire logic [3:0]  LINE_OUT_FOUND_I,
    input  wire logic [7:0]  CH_STATE_I,
    input  wire logic [3:0]  OVERCURRENT_I,
    input  wire logic [3:0]  DC_FAULT_I,
    input  wire logic        CLOCK_INVALID_I,
    input  wire logic        OUTPUT_SUPPLY_HIGH_FAULT_I,
    input  wire logic        BATTERY_HIGH_FAULT_I,
    input  wire logic        OUTPUT_SUPPLY_LOW_FAULT_I,
    input  wire logic        BATTERY_LOW_FAULT_I,
    input  wire logic [4:0]  THERMAL_SHUTDOWN_I
);
    adf_pkg::adf_state_t st_q;
    adf_pkg::adf_state_t st_d;
    logic [3:0]          nib_w [adf_pkg::NUM_CH];
    logic [4:0]          glob_w;

    // channel index 0 is channel 1; it sits in the high field everywhere
    function automatic logic [7:0] read_mux(input logic [7:0] a, input adf_pkg::adf_state_t s);
        logic [7:0] r;
        r = adf_pkg::UNMAPPED_DATA;
        case (a)
            adf_pkg::ADDR_LOAD_CH12:  r = s.load12;
            adf_pkg::ADDR_LOAD_CH34:  r = s.load34;
            adf_pkg::ADDR_LINE_OUT:   r = {4'h0, s.line_out};                // see [R4]
            adf_pkg::ADDR_CH_STATE:   r = s.ch_state;
            adf_pkg::ADDR_CH_FAULT:   r = s.ch_fault;
            adf_pkg::ADDR_SUPPLY_CLK: r = {3'h0, s.supply_clk};              // see [R10]
            adf_pkg::ADDR_THERMAL:    r = {3'h0, s.thermal};                 // see [R14]
            default:                  r = adf_pkg::UNMAPPED_DATA;
        endcase
        return r;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < adf_pkg::NUM_CH; gi++) begin : g_ch
            // a code below the threshold means resistance under the limit
            assign nib_w[gi] = {SHORT_TO_GROUND_I[gi], SHORT_TO_POWER_I[gi], OPEN_LOAD_I[gi],
                                (LOAD_CODE_I[4*gi +: 4] < SHORT_THRESHOLD_I[4*gi +: 4])}; // see [R15]
        end
    endgenerate

    assign glob_w = {CLOCK_INVALID_I, OUTPUT_SUPPLY_HIGH_FAULT_I, BATTERY_HIGH_FAULT_I,
                     OUTPUT_SUPPLY_LOW_FAULT_I, BATTERY_LOW_FAULT_I};

    always_comb begin
        st_d = st_q;
        // results are held until the channel's next diagnostic run
        if (DIAG_DONE_I[0]) begin
            st_d.load12[7:4] = nib_w[0];                                     // see [R2] see [R3]
        end
        if (DIAG_DONE_I[1]) begin
            st_d.load12[3:0] = nib_w[1];                                     // see [R2] see [R3]
        end
        if (DIAG_DONE_I[2]) begin
            st_d.load34[7:4] = nib_w[2];                                     // see [R1] see [R3]
        end
        if (DIAG_DONE_I[3]) begin
            st_d.load34[3:0] = nib_w[3];                                     // see [R1] see [R3]
        end
        for (int i = 0; i < adf_pkg::NUM_CH; i++) begin
            if (DIAG_DONE_I[i] && LINE_OUT_DIAG_ENABLE_I) begin
                st_d.line_out[3-i] = LINE_OUT_FOUND_I[i];                    // see [R4] see [R16]
            end else if (DIAG_DONE_I[i]) begin
                st_d.line_out[3-i] = 1'b0;                                   // see [R16]
            end
        end
        st_d.ch_state   = CH_STATE_I;                                        // see [R5] see [R6]
        st_d.ch_fault   = {OVERCURRENT_I[0], OVERCURRENT_I[1], OVERCURRENT_I[2], OVERCURRENT_I[3],
                           DC_FAULT_I[0], DC_FAULT_I[1], DC_FAULT_I[2], DC_FAULT_I[3]}; // see [R8] see [R9]
        st_d.supply_clk = glob_w;                                            // see [R11] see [R12] see [R13]
        st_d.thermal    = THERMAL_SHUTDOWN_I;                                // see [R14]
        // writes are accepted and dropped; nothing here is host-writable
        st_d.rvalid     = REG_RD_I;                                          // see [R17]
        st_d.rdata      = REG_RD_I ? read_mux(REG_ADDR_I, st_q) : st_q.rdata;
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!NRST_I) begin
            st_q.load12     <= adf_pkg::RST_LOAD;                            // see [R3]
            st_q.load34     <= adf_pkg::RST_LOAD;
            st_q.line_out   <= adf_pkg::RST_LINE_OUT;
            st_q.ch_state   <= adf_pkg::RST_CH_STATE;                        // see [R7]
            st_q.ch_fault   <= adf_pkg::RST_CH_FAULT;                        // see [R9]
            st_q.supply_clk <= adf_pkg::RST_GLOBAL;
            st_q.thermal    <= adf_pkg::RST_GLOBAL;
            st_q.rdata      <= adf_pkg::UNMAPPED_DATA;
            st_q.rvalid     <= 1'b0;
        end else if (CE_I) begin
            st_q <= st_d;
        end
    end

    assign REG_RDATA_O  = st_q.rdata;
    assign REG_RVALID_O = st_q.rvalid;

    // ---- checks ----
    sequence rd_of(logic [7:0] a);
        CE_I && REG_RD_I && REG_ADDR_I == a;
    endsequence
    sequence answered;
        REG_RVALID_O;
    endsequence

    reset_state_a: assert property (@(posedge REF_CLK_I)           // see [R7]
        $rose(NRST_I) |-> st_q.ch_state == 8'h55)
        else $error("channel state not 0x55 after reset");
    read_answer_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see [R17]
        (CE_I && REG_RD_I) |=> answered)
        else $error("read not answered next cycle");
    line_reserved_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see [R4]
        rd_of(adf_pkg::ADDR_LINE_OUT) |=> REG_RDATA_O[7:4] == 4'h0)
        else $error("line-out reserved bits not zero");
    glob_reserved_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see [R10]
        rd_of(adf_pkg::ADDR_SUPPLY_CLK) |=> REG_RDATA_O[7:5] == 3'h0)
        else $error("supply reserved bits not zero");
    clock_flag_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see [R11]
        (CE_I && CLOCK_INVALID_I) ##1 rd_of(adf_pkg::ADDR_SUPPLY_CLK) |=> REG_RDATA_O[4])
        else $error("clock fault flag missing");
    line_gate_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see [R16]
        (CE_I && DIAG_DONE_I[0] && !LINE_OUT_DIAG_ENABLE_I) |=> !st_q.line_out[3])
        else $error("line-out set while disabled");
    shorted_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see [R15]
        (CE_I && DIAG_DONE_I[3]) |=> st_q.load34[0] == $past(LOAD_CODE_I[15:12] < SHORT_THRESHOLD_I[15:12]))
        else $error("shorted-load judgement wrong");
    oc_order_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see [R8]
        CE_I |=> st_q.ch_fault[7] == $past(OVERCURRENT_I[0]) && st_q.ch_fault[0] == $past(DC_FAULT_I[3]))
        else $error("channel fault bit order wrong");
    write_ignored_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I) // see [R17]
        (CE_I && REG_WR_I && !(|DIAG_DONE_I)) |=> $stable(st_q.load12) && $stable(st_q.load34))
        else $error("write changed a status register");
    freeze_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        !CE_I |=> $stable(st_q))
        else $error("state moved with clock enable low");
endmodule

// ==== tb/adf_host_model.sv ====
/*
 * adf_host_model: host side of the status read port, with read and write tasks.
 * assumes: bus signals change only at the falling edge of the clock.
 */
module adf_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic            ce_o,
    output logic [7:0]      addr_o,
    output logic            rd_o,
    output logic            wr_o,
    output logic [7:0]      wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ce_o = 1'b1;
        addr_o = 8'h00;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 8'h00;
    end
    // reserved bits are returned as read; the caller decides what they mean
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        n = 0;
        while (rvalid_i !== 1'b1 && n < 4) begin
            @(negedge clk_i);
            n++;
        end
        d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
endmodule

// ==== tb/adf_status_bank_bench.sv ====
/*
 * adf_status_bank_bench: read-back tests of the status bank through the host model.
 * assumes: one clock, sync active-low reset, diag strobes driven by the bench.
 */
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module adf_status_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, ce, rd, wr, rvalid, lo_en = 1'b0;
    logic [7:0] addr, wdata, rdata, st = 8'h55;
    logic [3:0] done = 4'h0, s2g = 4'h0, s2p = 4'h0, ol = 4'h0, lo = 4'h0, oc = 4'h0, dc = 4'h0;
    logic [15:0] code = 16'h5555, thr = 16'h1111;
    logic [4:0] gl = 5'h00, th = 5'h00;
    int bad_count = 0, n_compared = 0, cyc = 0;
    always #2.5 clk = ~clk;
    adf_host_model host_u (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .ce_o(ce), .addr_o(addr),
        .rd_o(rd), .wr_o(wr), .wdata_o(wdata));
    adf_status_bank dut_u (.REF_CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .REG_ADDR_I(addr), .REG_RD_I(rd),
        .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
        .DIAG_DONE_I(done), .SHORT_TO_GROUND_I(s2g), .SHORT_TO_POWER_I(s2p), .OPEN_LOAD_I(ol),
        .LOAD_CODE_I(code), .SHORT_THRESHOLD_I(thr), .LINE_OUT_DIAG_ENABLE_I(lo_en), .LINE_OUT_FOUND_I(lo),
        .CH_STATE_I(st), .OVERCURRENT_I(oc), .DC_FAULT_I(dc), .CLOCK_INVALID_I(gl[4]),
        .OUTPUT_SUPPLY_HIGH_FAULT_I(gl[3]), .BATTERY_HIGH_FAULT_I(gl[2]), .OUTPUT_SUPPLY_LOW_FAULT_I(gl[1]),
        .BATTERY_LOW_FAULT_I(gl[0]), .THERMAL_SHUTDOWN_I(th));
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host_u.rd(a, d);
        `CHK(d, e)
    endtask
    // flags ride with the strobe only, code and enable stay; flags inverted afterwards so stale capture shows
    task automatic diag(input logic [3:0] d, g, p, o, input logic [15:0] c, input logic e, input logic [3:0] l);
        @(negedge clk);
        {done, s2g, s2p, ol, code, lo_en, lo} = {d, g, p, o, c, e, l};
        @(negedge clk);
        {done, s2g, s2p, ol, lo} = {4'h0, ~g, ~p, ~o, ~l};
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        for (int a = 12; a <= 18; a++) chk_rd(8'(a), (a == 15) ? 8'h55 : 8'h00);
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            st = {4{2'(c)}};
            chk_rd(8'h0F, {4{2'(c)}});
        end
        st = 8'h1B;
        chk_rd(8'h0F, 8'h1B);
        $display("test state done");
        for (int i = 0; i < 4; i++) begin
            oc = 4'h1 << i;
            dc = 4'h8 >> i;
            chk_rd(8'h10, (8'h80 >> i) | (8'h01 << i));
        end
        for (int i = 0; i < 5; i++) begin
            gl = 5'h10 >> i;
            th = 5'h01 << i;
            chk_rd(8'h11, {3'h0, 5'h10 >> i});
            chk_rd(8'h12, {3'h0, 5'h01 << i});
        end
        $display("test faults done");
        // ch1 code below threshold, ch2 exactly at it: only ch1 is shorted
        diag(4'hF, 4'b0100, 4'b0010, 4'b1000, 16'h5510, 1'b1, 4'b0101);
        chk_rd(8'h0C, 8'h14);
        chk_rd(8'h0D, 8'h82);
        chk_rd(8'h0E, 8'h0A);
        diag(4'b0001, 4'h0, 4'h0, 4'h0, 16'h5511, 1'b0, 4'hF);
        chk_rd(8'h0C, 8'h04);
        chk_rd(8'h0D, 8'h82);
        chk_rd(8'h0E, 8'h02);
        $display("test load done");
        host_u.wr(8'h0D, 8'hFF);
        host_u.wr(8'h0F, 8'h00);
        chk_rd(8'h0D, 8'h82);
        chk_rd(8'h0F, 8'h1B);
        chk_rd(8'h20, 8'h00);
        $display("test write done");
        // clock enable low must freeze capture: a pulse of faults meanwhile is never seen
        @(negedge clk);
        host_u.ce_o = 1'b0;
        oc = 4'hF;
        dc = 4'hF;
        repeat (3) @(negedge clk);
        oc = 4'h0;
        dc = 4'h0;
        host_u.ce_o = 1'b1;
        chk_rd(8'h10, 8'h00);
        $display("test freeze done");
        @(negedge clk);
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        for (int a = 12; a <= 14; a++) chk_rd(8'(a), 8'h00);
        $display("test rereset done");
        print_verdict();
    end
endmodule
